// >>> common/alsrd_pkg.sv
// constants shared by the ambient light readout sequencer
package alsrd_pkg;
  // serial bus addressing
  localparam logic [7:0] BUS_WR_ADDR   = 8'h26;
  localparam logic [7:0] BUS_RD_ADDR   = 8'h27;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // register pointer values
  localparam logic [7:0] REG_CMD       = 8'h80;
  localparam logic [7:0] REG_PARAM     = 8'h84;
  localparam logic [7:0] REG_RES_HI    = 8'h85;
  localparam logic [7:0] REG_RES_LO    = 8'h86;
  // field positions
  localparam int unsigned CMD_START_BIT = 4;
  localparam int unsigned CMD_BUSY_BIT  = 5;
  localparam int unsigned CMD_RDY_BIT   = 6;
  localparam int unsigned PAR_CONT_BIT  = 7;
  localparam int unsigned PAR_AVG_LSB   = 0;
  localparam int unsigned AVG_LOG_W     = 3;
  localparam logic [7:0]  PARAM_RESET   = 8'h00;
  // measurement timing
  localparam int unsigned CLK_KHZ       = 125000;
  localparam int unsigned FRAME_MS      = 100;
  localparam int unsigned CONV_US       = 300;
  localparam int unsigned FRAME_CYC_DEF = FRAME_MS * CLK_KHZ;
  localparam int unsigned CONV_CYC_DEF  = (CONV_US * CLK_KHZ) / 1000;
  localparam int unsigned MAX_AVG       = 128;
  localparam int unsigned RES_W         = 16;
  localparam int unsigned ACC_W         = 23;
  localparam int unsigned CNT_W         = 24;
  // serial interface states
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_ADDR  = 6'h02,
    S_AACK  = 6'h04,
    S_WRITE = 6'h08,
    S_WACK  = 6'h10,
    S_READ  = 6'h20
  } alsrd_bus_e;
  // conversion sequencer states
  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_CONV = 3'h2,
    C_HOLD = 3'h4
  } alsrd_conv_e;
endpackage

// >>> logic/alsrd_conv.sv
// averaging conversion sequencer with fixed frame and continuous modes
`timescale 1ns/100ps
module alsrd_conv #(
  parameter int unsigned FRAME_CYC = alsrd_pkg::FRAME_CYC_DEF,
  parameter int unsigned CONV_CYC  = alsrd_pkg::CONV_CYC_DEF
) (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // control
  input  wire logic                                start,
  input  wire logic                                cont_mode,
  input  wire logic [alsrd_pkg::AVG_LOG_W-1:0]     avg_log2,
  // converter
  input  wire logic [alsrd_pkg::RES_W-1:0]         adc_data,
  output logic                                     conv_start,
  // result
  output logic                                     busy,
  output logic                                     result_pulse,
  output logic [alsrd_pkg::RES_W-1:0]              result
);
  localparam logic [alsrd_pkg::CNT_W-1:0] FRAME_LAST = alsrd_pkg::CNT_W'(FRAME_CYC - 1);
  localparam logic [alsrd_pkg::CNT_W-1:0] CONV_LAST  = alsrd_pkg::CNT_W'(CONV_CYC - 1);

  if (CONV_CYC < 1 || FRAME_CYC < CONV_CYC * alsrd_pkg::MAX_AVG ||
      FRAME_CYC > (1 << alsrd_pkg::CNT_W)) begin : g_bad_timing
    $error("frame length outside what the counters can serve");
  end

  alsrd_pkg::alsrd_conv_e            state;
  logic [alsrd_pkg::CNT_W-1:0]       frame_cnt;
  logic [alsrd_pkg::CNT_W-1:0]       conv_cnt;
  logic [7:0]                        n_done;
  logic [7:0]                        n_last;
  logic [7:0]                        conv_seen;
  logic [alsrd_pkg::ACC_W-1:0]       acc;
  logic                              mode;
  logic [alsrd_pkg::AVG_LOG_W-1:0]   avg;
  logic                              conv_end;
  logic                              last_conv;

  // settings are frozen at start so a mid-burst write cannot skew the average
  assign n_last    = 8'((9'h001 << avg) - 9'h001);
  assign conv_end  = (state == alsrd_pkg::C_CONV) && (conv_cnt == CONV_LAST);
  assign last_conv = (n_done == n_last);
  assign busy      = (state != alsrd_pkg::C_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= alsrd_pkg::C_IDLE;
      conv_cnt     <= '0;
      n_done       <= '0;
      acc          <= '0;
      mode         <= 1'b0;
      avg          <= '0;
      conv_start   <= 1'b0;
      result_pulse <= 1'b0;
      result       <= '0;
    end else begin
      conv_start   <= 1'b0;
      result_pulse <= 1'b0;
      case (state)
        alsrd_pkg::C_IDLE: begin
          if (start) begin
            state      <= alsrd_pkg::C_CONV;
            mode       <= cont_mode;                    // R5
            avg        <= avg_log2;
            conv_cnt   <= '0;
            n_done     <= '0;
            acc        <= '0;
            conv_start <= 1'b1;
          end
        end
        alsrd_pkg::C_CONV: begin
          if (conv_end) begin
            acc <= acc + alsrd_pkg::ACC_W'(adc_data);
            if (!last_conv) begin
              conv_cnt   <= '0;                         // R9
              n_done     <= n_done + 8'h01;
              conv_start <= 1'b1;
            end else if (mode) begin
              state        <= alsrd_pkg::C_IDLE;        // R12
              result       <= alsrd_pkg::RES_W'((acc + alsrd_pkg::ACC_W'(adc_data)) >> avg);
              result_pulse <= 1'b1;
            end else begin
              state <= alsrd_pkg::C_HOLD;
              acc   <= alsrd_pkg::ACC_W'((acc + alsrd_pkg::ACC_W'(adc_data)) >> avg); // R7
            end
          end else begin
            conv_cnt <= conv_cnt + 1'b1;
          end
        end
        alsrd_pkg::C_HOLD: begin
          if (frame_cnt == FRAME_LAST) begin
            state        <= alsrd_pkg::C_IDLE;          // R8
            result       <= acc[alsrd_pkg::RES_W-1:0];
            result_pulse <= 1'b1;
          end
        end
        default: state <= alsrd_pkg::C_IDLE;
      endcase
    end
  end

  // frame timer runs from start for the whole standard cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= '0;
    end else if (state == alsrd_pkg::C_IDLE) begin
      frame_cnt <= '0;
    end else if (frame_cnt != FRAME_LAST) begin
      frame_cnt <= frame_cnt + 1'b1;                    // R6
    end
  end

  // independent count of started conversions, read only by the averaging check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_seen <= '0;
    end else if (state == alsrd_pkg::C_IDLE && start) begin
      conv_seen <= '0;
    end else if (conv_start) begin
      conv_seen <= conv_seen + 8'h01;
    end
  end

  chk_frame_len: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (result_pulse && !mode) |-> ($past(frame_cnt) == FRAME_LAST))
    else $error("standard result not at frame end");
  chk_std_hold: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (state == alsrd_pkg::C_HOLD && frame_cnt != FRAME_LAST) |=> !result_pulse)
    else $error("standard result before frame end");
  chk_avg_count: assert property (@(posedge clk) disable iff (!rst_n) // R7
    result_pulse |-> (conv_seen == 8'(9'h001 << avg)))
    else $error("wrong number of averaged conversions");
  chk_back_to_back: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (conv_end && !last_conv) |=> (conv_start && state == alsrd_pkg::C_CONV && conv_cnt == '0))
    else $error("gap between single conversions");
  chk_cont_ready: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (conv_end && last_conv && mode) |=> (result_pulse && state == alsrd_pkg::C_IDLE))
    else $error("continuous result not ready after last conversion");
endmodule

// >>> logic/alsrd_top.sv
// ambient light readout: serial register slave and measurement control
// Behaviour
// R1 - pointer increments after each byte read
// R2 - host addresses first register once, then reads
// R3 - bus address bytes 26h write, 27h read
// R4 - result high byte at 85h, low next
// R5 - param bit 7 selects continuous mode
// R6 - standard mode uses fixed 100 ms frame
// R7 - result averages configured count, up to 128
// R8 - standard result available only at frame end
// R9 - continuous mode runs conversions back to back
// R10 - host writes pointer only, then reads
// R11 - standby when no measurement, LED sink off
// R12 - continuous result ready after last conversion
`timescale 1ns/100ps
module alsrd_top #(
  parameter int unsigned FRAME_CYC = alsrd_pkg::FRAME_CYC_DEF,
  parameter int unsigned CONV_CYC  = alsrd_pkg::CONV_CYC_DEF
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // serial bus pins
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  // converter
  input  wire logic [alsrd_pkg::RES_W-1:0] adc_data,
  output logic                             conv_start,
  // power state
  output logic                             standby,
  output logic                             led_sink_en
);
  localparam logic [6:0] ADDR7 = alsrd_pkg::BUS_WR_ADDR[7:1];

  alsrd_pkg::alsrd_bus_e          state;
  logic                           scl_m;
  logic                           scl_s;
  logic                           scl_d;
  logic                           sda_m;
  logic                           sda_s;
  logic                           sda_d;
  logic                           scl_rise;
  logic                           scl_fall;
  logic                           bus_start;
  logic                           bus_stop;
  logic [3:0]                     bit_cnt;
  logic [7:0]                     shreg;
  logic [7:0]                     ptr;
  logic                           rw;
  logic                           ptr_phase;
  logic                           in_ack;
  logic                           nack;
  logic [7:0]                     param;
  logic                           start_req;
  logic                           rdy;
  logic                           wr_en;
  logic                           hi_read;
  logic [7:0]                     rd_data;
  logic                           busy;
  logic                           result_pulse;
  logic [alsrd_pkg::RES_W-1:0]    result;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;
  assign sda_out   = 1'b0;
  assign wr_en     = (state == alsrd_pkg::S_WRITE) && scl_fall &&
                     (bit_cnt == alsrd_pkg::BITS_PER_BYTE) && !ptr_phase;
  assign hi_read   = (state == alsrd_pkg::S_READ) && scl_fall && !in_ack &&
                     (bit_cnt == alsrd_pkg::BITS_PER_BYTE) && (ptr == alsrd_pkg::REG_RES_HI);

  // register read map; unmapped pointers read zero
  always_comb begin
    rd_data = 8'h00;
    case (ptr)
      alsrd_pkg::REG_CMD: begin
        rd_data[alsrd_pkg::CMD_RDY_BIT]  = rdy;
        rd_data[alsrd_pkg::CMD_BUSY_BIT] = busy;
      end
      alsrd_pkg::REG_PARAM:  rd_data = param;
      alsrd_pkg::REG_RES_HI: rd_data = result[15:8];          // R4
      alsrd_pkg::REG_RES_LO: rd_data = result[7:0];           // R4
      default:               rd_data = 8'h00;
    endcase
  end

  // serial slave; the host sets the pointer by a write with no data byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= alsrd_pkg::S_IDLE;
      bit_cnt   <= '0;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      rw        <= 1'b0;
      ptr_phase <= 1'b0;
      in_ack    <= 1'b0;
      nack      <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (bus_start) begin
      state   <= alsrd_pkg::S_ADDR;
      bit_cnt <= '0;
      sda_oe  <= 1'b0;
    end else if (bus_stop) begin
      state  <= alsrd_pkg::S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        alsrd_pkg::S_IDLE: sda_oe <= 1'b0;
        alsrd_pkg::S_ADDR, alsrd_pkg::S_WRITE: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == alsrd_pkg::BITS_PER_BYTE) begin
            if (state == alsrd_pkg::S_ADDR) begin
              if (shreg[7:1] == ADDR7) begin                 // R3
                state  <= alsrd_pkg::S_AACK;
                rw     <= shreg[0];
                sda_oe <= 1'b1;
              end else begin
                state <= alsrd_pkg::S_IDLE;
              end
            end else begin
              state     <= alsrd_pkg::S_WACK;
              sda_oe    <= 1'b1;
              ptr_phase <= 1'b0;
              ptr       <= ptr_phase ? shreg : ptr + 8'h01;  // R10
            end
          end
        end
        alsrd_pkg::S_AACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            if (rw) begin
              state  <= alsrd_pkg::S_READ;
              in_ack <= 1'b0;
              shreg  <= rd_data;                             // R2
              sda_oe <= !rd_data[7];
            end else begin
              state     <= alsrd_pkg::S_WRITE;
              ptr_phase <= 1'b1;
              sda_oe    <= 1'b0;
            end
          end
        end
        alsrd_pkg::S_WACK: begin
          if (scl_fall) begin
            state   <= alsrd_pkg::S_WRITE;
            bit_cnt <= '0;
            sda_oe  <= 1'b0;
          end
        end
        alsrd_pkg::S_READ: begin
          if (in_ack) begin
            if (scl_rise) begin
              nack <= sda_s;
            end else if (scl_fall) begin
              in_ack  <= 1'b0;
              bit_cnt <= '0;
              if (nack) begin
                state <= alsrd_pkg::S_IDLE;
              end else begin
                shreg  <= rd_data;
                sda_oe <= !rd_data[7];
              end
            end
          end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == alsrd_pkg::BITS_PER_BYTE) begin
              in_ack <= 1'b1;
              sda_oe <= 1'b0;
              ptr    <= ptr + 8'h01;                         // R1
            end else begin
              shreg  <= {shreg[6:0], 1'b0};
              sda_oe <= !shreg[6];
            end
          end
        end
        default: state <= alsrd_pkg::S_IDLE;
      endcase
    end
  end

  // writable registers; start is a one-cycle request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      param     <= alsrd_pkg::PARAM_RESET;
      start_req <= 1'b0;
    end else begin
      start_req <= wr_en && (ptr == alsrd_pkg::REG_CMD) && shreg[alsrd_pkg::CMD_START_BIT];
      if (wr_en && ptr == alsrd_pkg::REG_PARAM) begin
        param <= shreg;                                      // R5
      end
    end
  end

  // ready flag: a new result in the same cycle as the clearing read wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy <= 1'b0;
    end else if (result_pulse) begin
      rdy <= 1'b1;
    end else if (hi_read) begin
      rdy <= 1'b0;
    end
  end

  // ambient measurement never drives the emitter
  assign standby     = !busy;                                // R11
  assign led_sink_en = 1'b0;                                 // R11

  alsrd_conv #(
    .FRAME_CYC (FRAME_CYC),
    .CONV_CYC  (CONV_CYC)
  ) u_conv (
    .clk          (clk),
    .rst_n        (rst_n),
    .start        (start_req),
    .cont_mode    (param[alsrd_pkg::PAR_CONT_BIT]),
    .avg_log2     (param[alsrd_pkg::PAR_AVG_LSB +: alsrd_pkg::AVG_LOG_W]),
    .adc_data     (adc_data),
    .conv_start   (conv_start),
    .busy         (busy),
    .result_pulse (result_pulse),
    .result       (result)
  );

  chk_ptr_incr: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (state == alsrd_pkg::S_READ && !in_ack && !bus_start && !bus_stop && scl_fall &&
     bit_cnt == alsrd_pkg::BITS_PER_BYTE) |=> (ptr == $past(ptr) + 8'h01))
    else $error("pointer did not advance after read byte");
  chk_addr_match: assert property (@(posedge clk) disable iff (!rst_n) // R3
    (state == alsrd_pkg::S_AACK) |-> (sda_oe && shreg[7:1] == ADDR7))
    else $error("acknowledged a foreign bus address");
  chk_high_first: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (state == alsrd_pkg::S_AACK && rw && scl_fall && !bus_start && !bus_stop &&
     ptr == alsrd_pkg::REG_RES_HI) |=> (shreg == $past(result[15:8])))
    else $error("result high byte not returned first");
  chk_mode_sel: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (wr_en && ptr == alsrd_pkg::REG_PARAM && !bus_start && !bus_stop) |=>
    (param[alsrd_pkg::PAR_CONT_BIT] == $past(shreg[alsrd_pkg::PAR_CONT_BIT])))
    else $error("mode bit not taken from write");
endmodule

// >>> verif/alsrd_host.sv
// bus host model: drives the serial clock and pulls the data wire low
`timescale 1ns/100ps
module alsrd_host #(
  parameter int unsigned HALF = 4
) (
  // clock
  input  wire logic clk,
  // bus pins
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int unsigned n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data moves only mid low phase, so it never races the clock edge
  task automatic xfer_bit(input logic b, output logic r);
    w(HALF);
    sda_low = ~b;
    w(HALF);
    scl = 1'b1;
    w(2 * HALF);
    r = sda;
    scl = 1'b0;
  endtask
  // also used as repeated start
  task automatic start_cond();
    w(HALF);
    sda_low = 1'b0;
    w(HALF);
    scl = 1'b1;
    w(2 * HALF);
    sda_low = 1'b1;
    w(2 * HALF);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    w(HALF);
    sda_low = 1'b1;
    w(HALF);
    scl = 1'b1;
    w(2 * HALF);
    sda_low = 1'b0;
    w(2 * HALF);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask
  // ack high keeps the read going, low ends it
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, b[i]);
    end
    xfer_bit(~ack, r);
  endtask
endmodule

// >>> verif/alsrd_top_tb.sv
// self-checking bench for the ambient light readout
`timescale 1ns/100ps
module alsrd_top_tb;
  localparam int unsigned FRAME = 2000;
  localparam int unsigned CONV  = 10;
  localparam int unsigned LIMIT = 45000;
  logic        clk;
  logic        rst_n;
  logic        scl;
  logic        sda_low;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic [15:0] adc_data;
  logic        conv_start;
  logic        standby;
  logic        led_sink_en;
  logic [31:0] rng;
  int unsigned mismatches;
  int unsigned checked;
  int unsigned cyc;
  int unsigned conv_cnt;
  int unsigned first_conv;
  int unsigned last_conv;
  int unsigned sum;
  // pull-up: high unless some party pulls it down
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  alsrd_top #(.FRAME_CYC(FRAME), .CONV_CYC(CONV)) alsrd_top_i (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .adc_data(adc_data), .conv_start(conv_start),
    .standby(standby), .led_sink_en(led_sink_en));
  alsrd_host #(.HALF(4)) alsrd_host_i (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expd, input string what);
    checked++;
    if (seen !== expd) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // each conversion gets a fresh sample, held until the next one starts
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end else if (conv_start === 1'b1) begin
      if (conv_cnt == 0) begin
        first_conv = cyc;
      end else begin
        check(16'(cyc - last_conv), 16'(CONV), "conversion spacing");
      end
      last_conv = cyc;
      conv_cnt++;
      #1;
      rng = xorshift(rng);
      adc_data = rng[15:0];
      sum += adc_data;
    end
  end
  task automatic addr_ptr(input logic [7:0] ptr);
    logic a;
    alsrd_host_i.start_cond();
    alsrd_host_i.send_byte(alsrd_pkg::BUS_WR_ADDR, a);
    check(16'(a), 16'h0001, "write address ack");
    alsrd_host_i.send_byte(ptr, a);
  endtask
  task automatic set_ptr(input logic [7:0] ptr);
    addr_ptr(ptr);
    alsrd_host_i.stop_cond();
  endtask
  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] val);
    logic a;
    addr_ptr(ptr);
    alsrd_host_i.send_byte(val, a);
    alsrd_host_i.stop_cond();
  endtask
  task automatic read_one(output logic [7:0] b);
    logic a;
    alsrd_host_i.start_cond();
    alsrd_host_i.send_byte(alsrd_pkg::BUS_RD_ADDR, a);
    check(16'(a), 16'h0001, "read address ack");
    alsrd_host_i.recv_byte(1'b0, b);
    alsrd_host_i.stop_cond();
  endtask
  task automatic read_status(input logic [1:0] expd);
    logic [7:0] b;
    set_ptr(alsrd_pkg::REG_CMD);
    read_one(b);
    check(16'(b[6:5]), 16'(expd), "ready and busy");
  endtask
  // two separate read transactions, addressed once
  task automatic read_result(input logic [15:0] expd);
    logic [7:0] hi;
    logic [7:0] lo;
    set_ptr(alsrd_pkg::REG_RES_HI);
    read_one(hi);
    read_one(lo);
    check({hi, lo}, expd, "result");
  endtask
  task automatic measure(input logic cm, input logic [2:0] lg);
    int unsigned t;
    reg_write(alsrd_pkg::REG_PARAM, {cm, 4'h0, lg});
    conv_cnt = 0;
    sum = 0;
    reg_write(alsrd_pkg::REG_CMD, 8'h10);
    t = cyc;
    while (conv_cnt < (1 << lg) && cyc < t + FRAME) @(posedge clk);
    if (cm) begin
      repeat (CONV + 2) @(posedge clk);
      read_status(2'h2);
    end else begin
      while (cyc < first_conv + FRAME - 600) @(posedge clk);
      check(16'(standby), 16'h0000, "standby while measuring");
      read_status(2'h1);
      while (cyc < first_conv + FRAME + 20) @(posedge clk);
      read_status(2'h2);
    end
    check(16'({standby, led_sink_en}), 16'h0002, "power after run");
    read_result(16'(sum >> lg));
    check(16'(conv_cnt), 16'(1 << lg), "conversion count");
    read_status(2'h0);
  endtask
  initial begin
    logic       a;
    logic       cm;
    logic [2:0] lg;
    logic [7:0] b;
    rst_n = 1'b0;
    adc_data = 16'h0000;
    rng = 32'h0000_cd8e;
    mismatches = 0;
    checked = 0;
    cyc = 0;
    conv_cnt = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    check(16'({standby, led_sink_en}), 16'h0002, "idle power state");
    read_result(16'h0000);
    alsrd_host_i.start_cond();
    alsrd_host_i.send_byte(8'h28, a);
    check(16'(a), 16'h0000, "foreign address ack");
    alsrd_host_i.stop_cond();
    // repeated start after the pointer write, then one burst over two registers
    reg_write(alsrd_pkg::REG_PARAM, 8'h85);
    addr_ptr(alsrd_pkg::REG_PARAM);
    alsrd_host_i.start_cond();
    alsrd_host_i.send_byte(alsrd_pkg::BUS_RD_ADDR, a);
    check(16'(a), 16'h0001, "burst address ack");
    alsrd_host_i.recv_byte(1'b1, b);
    check(16'(b), 16'h0085, "parameter readback");
    alsrd_host_i.recv_byte(1'b0, b);
    check(16'(b), 16'h0000, "next register in burst");
    alsrd_host_i.stop_cond();
    // fixed cases first: standard with 1 and 128 samples, continuous with 2 and 128, then random mode and count
    for (int m = 0; m < 6; m++) begin
      rng = xorshift(rng);
      cm = (m < 4) ? (m >= 2) : rng[7];
      lg = (m < 4) ? 3'(m[0] ? 7 : (m >> 1)) : rng[2:0];
      measure(cm, lg);
    end
    tally_and_finish();
  end
endmodule
